// [gpx_pkg.sv]
// How it works
// [R1] Direction bit zero makes pin input
// [R2] Input pin reads back sampled level
// [R3] Latch write on input leaves pin undriven
// [R4] Bit X of registers maps pin X
// [R5] Direction one drives latch onto pin
// [R6] Output pin reads back stored latch
// [R7] Option bit picks push-pull or open-drain
// [R8] Direction/option pair selects pin mode
// [R9] Interrupt input uses group sensitivity setting
// [R10] Per-pin detections ORed into group request
// [R11] Request latch hidden, cleared on vector fetch
// [R12] Sensitivity change clears pending request
// [R13] Alternate function overrides port programming
// [R14] Peripheral source forces output, its drive type
// [R15] Peripheral input pin level still readable
// [R16] Shared peripheral pin kept floating input
// [R17] Software loads latch before output switch
// [R18] Software avoids read-modify-write on latch
// [R19] Input with alternate output reads alternate
// [R20] Interrupt only when selected and unmasked
// [R21] Reset clears latch, direction, option
package gpx_pkg;

  localparam int unsigned PIN_W = 8;

  // Byte addresses on APB
  localparam logic [7:0] ADDR_DATA  = 8'h00;
  localparam logic [7:0] ADDR_DIR   = 8'h04;
  localparam logic [7:0] ADDR_OPT   = 8'h08;
  localparam logic [7:0] ADDR_SENS  = 8'h0c;
  localparam logic [7:0] ADDR_STAT  = 8'h10;

  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR  = 8'h00;
  localparam logic [7:0] RST_OPT  = 8'h00;
  localparam logic [2:0] RST_SENS = 3'h0;

  // Sensitivity field: bit 2 polarity invert, bits 1:0 select
  localparam int unsigned SENS_POL = 2;

  typedef enum logic [1:0] {
    SENS_FALL_LOW = 2'b00,
    SENS_RISE     = 2'b01,
    SENS_FALL     = 2'b10,
    SENS_BOTH     = 2'b11
  } gpx_sens_e;

  typedef struct packed {
    logic [7:0] psel_en;
    logic [7:0] drive;
    logic [7:0] open_drain;
  } gpx_alt_s;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gpx_apb_s;

endpackage : gpx_pkg

// [gpx_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for the pad inputs
module gpx_sync (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] d_i,
  output logic      [7:0] q_o
);
  logic [7:0] s1_r;
  logic [7:0] s1_nxt;
  logic [7:0] q_nxt;

  always_comb begin
    s1_nxt = d_i;
    q_nxt  = s1_r;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_r <= 8'h00;
      q_o  <= 8'h00;
    end else begin
      s1_r <= s1_nxt;
      q_o  <= q_nxt;
    end
  end
endmodule : gpx_sync

// [gpx_port.sv]
`timescale 1ns/1ps
module gpx_port (
  input  wire logic        CLK_SYS_I,
  input  wire logic        NRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [7:0]  PIN_I,
  output logic      [7:0]  PIN_O,
  output logic      [7:0]  PIN_OE_O,
  output logic      [7:0]  PULLUP_EN_O,
  input  wire logic [7:0]  ALT_EN_I,
  input  wire logic [7:0]  ALT_DRIVE_I,
  input  wire logic [7:0]  ALT_OPEN_DRAIN_I,
  input  wire logic [7:0]  IRQ_CAPABLE_I,
  input  wire logic        IRQ_MASK_I,
  input  wire logic        VECTOR_FETCH_I,
  output logic             EXT_IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  gpx_pkg::gpx_apb_s apb;
  gpx_pkg::gpx_alt_s alt;
  logic [7:0] pin_s;

  assign apb = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                 paddr: PADDR_I, pwdata: PWDATA_I};
  assign alt = '{psel_en: ALT_EN_I, drive: ALT_DRIVE_I, open_drain: ALT_OPEN_DRAIN_I};

  gpx_sync u_sync (
    .clk_i  (CLK_SYS_I),
    .nrst_i (NRST_I),
    .d_i    (PIN_I),
    .q_o    (pin_s)
  );

  // Event detector for one pin under the group sensitivity
  function automatic logic detect(input logic cur, input logic prev, input logic [2:0] sens);
    logic c;
    logic p;
    c = cur ^ sens[gpx_pkg::SENS_POL];
    p = prev ^ sens[gpx_pkg::SENS_POL];
    case (sens[1:0])
      gpx_pkg::SENS_FALL_LOW: detect = !c;
      gpx_pkg::SENS_RISE:     detect = c & !p;
      gpx_pkg::SENS_FALL:     detect = !c & p;
      default:                detect = c ^ p;
    endcase
  endfunction : detect

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] data_r, data_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] opt_r, opt_nxt;
  logic [2:0] sens_r, sens_nxt;
  logic [7:0] prev_r, prev_nxt;
  logic       pend_r, pend_nxt;
  logic [31:0] prdata_nxt;
  logic       pslverr_nxt;
  logic       access;
  logic       setup;
  logic       wr;
  logic [7:0] irq_sel;
  logic [7:0] hit;
  logic [7:0] rd_data;
  logic [7:0] alt_out;

  assign access  = apb.psel & apb.penable;
  assign setup   = apb.psel & !apb.penable;
  assign wr      = access & apb.pwrite;
  assign irq_sel = ~dir_r & opt_r & IRQ_CAPABLE_I & ~alt.psel_en;  // see [R8]
  assign alt_out = alt.psel_en & alt.drive;

  always_comb begin
    // Input pins show the pad (peripheral pins the alternate drive), output pins the latch
    for (int i = 0; i < gpx_pkg::PIN_W; i++) begin  // see [R4]
      if (alt.psel_en[i] && !dir_r[i]) begin
        rd_data[i] = alt.drive[i];  // see [R19]
      end else if (dir_r[i]) begin
        rd_data[i] = data_r[i];  // see [R6]
      end else begin
        rd_data[i] = pin_s[i];  // see [R2] see [R15]
      end
      hit[i] = irq_sel[i] & detect(pin_s[i], prev_r[i], sens_r);  // see [R9]
    end
  end

  always_comb begin
    data_nxt    = data_r;
    dir_nxt     = dir_r;
    opt_nxt     = opt_r;
    sens_nxt    = sens_r;
    prev_nxt    = pin_s;
    pend_nxt    = pend_r;
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (wr) begin
      case (apb.paddr)
        gpx_pkg::ADDR_DATA: data_nxt = apb.pwdata[7:0];  // see [R3] see [R5]
        gpx_pkg::ADDR_DIR:  dir_nxt  = apb.pwdata[7:0];
        gpx_pkg::ADDR_OPT:  opt_nxt  = apb.pwdata[7:0];
        gpx_pkg::ADDR_SENS: sens_nxt = apb.pwdata[2:0];
        default:            ;
      endcase
    end
    // Answer is prepared in the setup cycle so it stands while ready is high
    if (setup && apb.pwrite) begin
      case (apb.paddr)
        gpx_pkg::ADDR_DATA, gpx_pkg::ADDR_DIR, gpx_pkg::ADDR_OPT, gpx_pkg::ADDR_SENS: pslverr_nxt = 1'b0;
        default:            pslverr_nxt = 1'b1;
      endcase
    end else if (setup) begin
      case (apb.paddr)
        gpx_pkg::ADDR_DATA: prdata_nxt = {24'h00_0000, rd_data};
        gpx_pkg::ADDR_DIR:  prdata_nxt = {24'h00_0000, dir_r};
        gpx_pkg::ADDR_OPT:  prdata_nxt = {24'h00_0000, opt_r};
        gpx_pkg::ADDR_SENS: prdata_nxt = {29'h0000_0000, sens_r};
        gpx_pkg::ADDR_STAT: prdata_nxt = {24'h00_0000, pin_s};
        default:            pslverr_nxt = 1'b1;
      endcase
    end
    // Clear first so a fresh event in the same cycle still wins
    if (VECTOR_FETCH_I) begin
      pend_nxt = 1'b0;  // see [R11]
    end
    if (wr && apb.paddr == gpx_pkg::ADDR_SENS && apb.pwdata[2:0] != sens_r) begin
      pend_nxt = 1'b0;  // see [R12]
    end
    // A hit in the cycle of a sensitivity write is dropped, so it cannot undo the clear
    if (|hit && !(wr && apb.paddr == gpx_pkg::ADDR_SENS)) begin
      pend_nxt = 1'b1;  // see [R10]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      data_r    <= gpx_pkg::RST_DATA;  // see [R21]
      dir_r     <= gpx_pkg::RST_DIR;
      opt_r     <= gpx_pkg::RST_OPT;
      sens_r    <= gpx_pkg::RST_SENS;
      prev_r    <= 8'h00;
      pend_r    <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      data_r    <= data_nxt;
      dir_r     <= dir_nxt;
      opt_r     <= opt_nxt;
      sens_r    <= sens_nxt;
      prev_r    <= prev_nxt;
      pend_r    <= pend_nxt;
      PRDATA_O  <= prdata_nxt;
      PSLVERR_O <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive
  logic [7:0] pin_nxt, oe_nxt, pu_nxt;
  logic       irq_nxt;
  logic       ready_nxt;

  always_comb begin
    for (int i = 0; i < gpx_pkg::PIN_W; i++) begin
      if (alt.psel_en[i]) begin
        // Peripheral owns the pin  see [R13] see [R14]
        pin_nxt[i] = alt.drive[i];
        oe_nxt[i]  = alt.open_drain[i] ? !alt.drive[i] : 1'b1;
        pu_nxt[i]  = 1'b0;
      end else if (dir_r[i]) begin
        // Push-pull or open-drain  see [R5] see [R7]
        pin_nxt[i] = data_r[i];
        oe_nxt[i]  = opt_r[i] ? 1'b1 : !data_r[i];
        pu_nxt[i]  = 1'b0;
      end else begin
        // Input stays undriven  see [R1] see [R3]
        pin_nxt[i] = 1'b0;
        oe_nxt[i]  = 1'b0;
        pu_nxt[i]  = opt_r[i];  // see [R8]
      end
    end
    irq_nxt   = pend_r & !IRQ_MASK_I;  // see [R20]
    ready_nxt = PSEL_I & !PENABLE_I;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      PIN_O       <= 8'h00;
      PIN_OE_O    <= 8'h00;
      PULLUP_EN_O <= 8'h00;
      EXT_IRQ_O   <= 1'b0;
      PREADY_O    <= 1'b0;
    end else begin
      PIN_O       <= pin_nxt;
      PIN_OE_O    <= oe_nxt;
      PULLUP_EN_O <= pu_nxt;
      EXT_IRQ_O   <= irq_nxt;
      PREADY_O    <= ready_nxt;
    end
  end

endmodule : gpx_port

// [gpx_pads.sv]
`timescale 1ns/1ps
// Board side of the pads: outside drivers, pull-ups and floating nodes
module gpx_pads (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_oe_i,
  output logic      [7:0] lvl_o
);
  logic [7:0] last_r = 8'h00;
  // A node nobody drives or pulls up must not hold its old level, so it flips each cycle
  always_ff @(posedge clk_i) last_r <= lvl_o;
  always_comb lvl_o = (oe_i & drv_i) | (~oe_i & ext_oe_i & ext_i) | (~oe_i & ~ext_oe_i & (pu_i | ~last_r));
endmodule : gpx_pads

// [gpx_port_properties.sv]
`timescale 1ns/1ps
module gpx_port_props (
  input wire logic        CLK_SYS_I,
  input wire logic        NRST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic        PREADY_O,
  input wire logic        IRQ_MASK_I,
  input wire logic        VECTOR_FETCH_I,
  input wire logic        EXT_IRQ_O,
  input wire logic [7:0]  PADDR_I,
  input wire logic [7:0]  PIN_I,
  input wire logic [7:0]  PIN_O,
  input wire logic [7:0]  PIN_OE_O,
  input wire logic [7:0]  PULLUP_EN_O,
  input wire logic [7:0]  ALT_EN_I,
  input wire logic [7:0]  ALT_DRIVE_I,
  input wire logic [7:0]  ALT_OPEN_DRAIN_I,
  input wire logic [31:0] PWDATA_I
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  logic [7:0] lat_r, dir_r, opt_r, pin_r, oe_e, v_e;
  logic [2:0] sens_r, q_r;
  logic       wr;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  // Shadow of the written registers, so pin outputs can be tied to bus writes
  always_ff @(posedge CLK_SYS_I) begin
    pin_r <= PIN_I;
    q_r <= (PIN_I != pin_r) ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
    if (!NRST_I) {lat_r, dir_r, opt_r, sens_r, q_r} <= '0;
    else if (wr) case (PADDR_I)
      gpx_pkg::ADDR_DATA: lat_r <= PWDATA_I[7:0];
      gpx_pkg::ADDR_DIR:  dir_r <= PWDATA_I[7:0];
      gpx_pkg::ADDR_OPT:  opt_r <= PWDATA_I[7:0];
      gpx_pkg::ADDR_SENS: sens_r <= PWDATA_I[2:0];
      default: ;
    endcase
  end
  assign oe_e = (ALT_EN_I & (~ALT_OPEN_DRAIN_I | ~ALT_DRIVE_I)) | (~ALT_EN_I & dir_r & (opt_r | ~lat_r));
  assign v_e = (ALT_EN_I & ALT_DRIVE_I) | (~ALT_EN_I & lat_r);
  oe_map_a: assert property (1 |=> PIN_OE_O == $past(oe_e))
    else $error("pin enable wrong");
  drive_val_a: assert property (1 |=> (PIN_O & $past(oe_e)) == $past(v_e & oe_e))
    else $error("pin drive wrong");
  pullup_sel_a: assert property (1 |=> (PULLUP_EN_O & ~$past(ALT_EN_I)) == $past(~ALT_EN_I & ~dir_r & opt_r))
    else $error("pull-up wrong");
  irq_mask_a: assert property (EXT_IRQ_O |-> !$past(IRQ_MASK_I))
    else $error("irq while masked");
  fetch_clr_a: assert property (VECTOR_FETCH_I && q_r == 3'h7 && sens_r[1:0] != 2'h0 |=> ##1 !EXT_IRQ_O)
    else $error("fetch did not clear");
  sens_clr_a: assert property (wr && PADDR_I == gpx_pkg::ADDR_SENS && PWDATA_I[2:0] != sens_r |=> ##1 !EXT_IRQ_O)
    else $error("sens write did not clear");
  reset_out_a: assert property (disable iff (1'b0) !NRST_I |=> PIN_OE_O == 8'h00 && PULLUP_EN_O == 8'h00 && !EXT_IRQ_O)
    else $error("outputs active in reset");
  ready_once_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("ready timing wrong");
  cover property (EXT_IRQ_O);
  cover property (|(PIN_OE_O & ALT_EN_I));
  cover property (|PULLUP_EN_O);
endmodule : gpx_port_props
////////////////////////////////////////////////////////////////
bind gpx_port gpx_port_props u_props (
  .CLK_SYS_I        (CLK_SYS_I),
  .NRST_I           (NRST_I),
  .PSEL_I           (PSEL_I),
  .PENABLE_I        (PENABLE_I),
  .PWRITE_I         (PWRITE_I),
  .PREADY_O         (PREADY_O),
  .IRQ_MASK_I       (IRQ_MASK_I),
  .VECTOR_FETCH_I   (VECTOR_FETCH_I),
  .EXT_IRQ_O        (EXT_IRQ_O),
  .PADDR_I          (PADDR_I),
  .PIN_I            (PIN_I),
  .PIN_O            (PIN_O),
  .PIN_OE_O         (PIN_OE_O),
  .PULLUP_EN_O      (PULLUP_EN_O),
  .ALT_EN_I         (ALT_EN_I),
  .ALT_DRIVE_I      (ALT_DRIVE_I),
  .ALT_OPEN_DRAIN_I (ALT_OPEN_DRAIN_I),
  .PWDATA_I         (PWDATA_I)
);

// [gpx_port_tb.sv]
`timescale 1ns/1ps
module gpx_port_tb;
  logic        CLK_SYS_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I, IRQ_MASK_I, VECTOR_FETCH_I, PREADY_O, PSLVERR_O, EXT_IRQ_O;
  logic [7:0]  PADDR_I, ALT_EN_I, ALT_DRIVE_I, ALT_OPEN_DRAIN_I, IRQ_CAPABLE_I, PIN_O, PIN_OE_O, PULLUP_EN_O;
  logic [7:0]  ext, ext_oe, v, l, o, a, d;
  logic [31:0] PWDATA_I, PRDATA_O;
  wire  [7:0]  PIN_I;
  logic [8:0]  e, exp_q[$];
  logic [2:0]  s, k;
  int          bad_count, cmp_count, cyc, seed;
  gpx_port DUT (
    .CLK_SYS_I (CLK_SYS_I), .NRST_I (NRST_I), .PSEL_I (PSEL_I), .PENABLE_I (PENABLE_I), .PWRITE_I (PWRITE_I),
    .PADDR_I (PADDR_I), .PWDATA_I (PWDATA_I), .PRDATA_O (PRDATA_O), .PREADY_O (PREADY_O),
    .PSLVERR_O (PSLVERR_O), .PIN_I (PIN_I), .PIN_O (PIN_O), .PIN_OE_O (PIN_OE_O), .PULLUP_EN_O (PULLUP_EN_O),
    .ALT_EN_I (ALT_EN_I), .ALT_DRIVE_I (ALT_DRIVE_I), .ALT_OPEN_DRAIN_I (ALT_OPEN_DRAIN_I),
    .IRQ_CAPABLE_I (IRQ_CAPABLE_I), .IRQ_MASK_I (IRQ_MASK_I), .VECTOR_FETCH_I (VECTOR_FETCH_I),
    .EXT_IRQ_O (EXT_IRQ_O)
  );
  gpx_pads u_pads (.clk_i(CLK_SYS_I), .drv_i(PIN_O), .oe_i(PIN_OE_O), .pu_i(PULLUP_EN_O), .ext_i(ext),
                   .ext_oe_i(ext_oe), .lvl_o(PIN_I));
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end
  task automatic chk(input logic [8:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic wt(input int n);
    repeat (n) @(posedge CLK_SYS_I);
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] ad, dt, input logic [8:0] ex);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= ad;
    PWDATA_I <= {24'h0, dt};
    if (!w) exp_q.push_back(ex);
    wt(1);
    PENABLE_I <= 1'b1;
    do wt(1); while (PREADY_O !== 1'b1);
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    wt(1);
  endtask : apb
  ////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      final_report;
    end
    if (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I) begin
      e = exp_q.pop_front();
      chk({PSLVERR_O, PRDATA_O[7:0] & {8{!e[8]}}}, e);
    end
  end
  initial begin
    seed = 72199;
    {NRST_I, PSEL_I, PENABLE_I, PWRITE_I, IRQ_MASK_I, VECTOR_FETCH_I, PADDR_I, PWDATA_I} = '0;
    {ALT_EN_I, ALT_DRIVE_I, ALT_OPEN_DRAIN_I, ext} = '0;
    IRQ_CAPABLE_I = 8'hff;
    ext_oe = 8'hff;
    wt(16);
    NRST_I <= 1'b1;
    wt(1);
    apb(1'b0, gpx_pkg::ADDR_DIR, 8'h0, 9'h0);
    apb(1'b0, gpx_pkg::ADDR_SENS, 8'h0, 9'h0);
    apb(1'b0, 8'h20, 8'h0, 9'h100);
    v = 8'($random(seed));
    l = 8'($random(seed));
    o = 8'($random(seed));
    ext <= v;
    wt(4);
    apb(1'b0, gpx_pkg::ADDR_DATA, 8'h0, {1'b0, v});
    // Latch is written whole before the pins turn round, never bit by bit
    apb(1'b1, gpx_pkg::ADDR_DATA, l, 9'h0);
    apb(1'b0, gpx_pkg::ADDR_DATA, 8'h0, {1'b0, v});
    apb(1'b1, gpx_pkg::ADDR_OPT, o, 9'h0);
    ext_oe <= 8'h0;
    apb(1'b1, gpx_pkg::ADDR_DIR, 8'hff, 9'h0);
    wt(3);
    chk({1'b0, PIN_I & (o | ~l)}, {1'b0, l & o});
    apb(1'b0, gpx_pkg::ADDR_DATA, 8'h0, {1'b0, l});
    apb(1'b1, gpx_pkg::ADDR_DIR, 8'h0, 9'h0);
    apb(1'b1, gpx_pkg::ADDR_OPT, 8'hff, 9'h0);
    wt(3);
    apb(1'b0, gpx_pkg::ADDR_DATA, 8'h0, 9'h0ff);
    // Pins shared with a peripheral stay floating inputs
    apb(1'b1, gpx_pkg::ADDR_OPT, 8'h0, 9'h0);
    a = 8'($random(seed));
    d = 8'($random(seed));
    ALT_EN_I <= a;
    ALT_DRIVE_I <= d;
    ext_oe <= ~a;
    wt(4);
    apb(1'b0, gpx_pkg::ADDR_DATA, 8'h0, {1'b0, (a & d) | (~a & v)});
    ALT_OPEN_DRAIN_I <= 8'($random(seed));
    wt(3);
    ALT_EN_I <= 8'h0;
    ext_oe <= 8'hff;
    ext <= 8'hff;
    apb(1'b1, gpx_pkg::ADDR_OPT, 8'hff, 9'h0);
    // A changed sensitivity drops whatever earlier phases left pending
    apb(1'b1, gpx_pkg::ADDR_SENS, 8'h06, 9'h0);
    for (int i = 0; i < 5; i++) begin
      s = (i == 4) ? 3'h5 : 3'(i);
      k = 3'($random(seed));
      apb(1'b1, gpx_pkg::ADDR_SENS, {5'h0, s}, 9'h0);
      wt(8);
      ext <= ~(8'h01 << k);
      wt(8);
      chk({8'h0, EXT_IRQ_O}, {8'h0, s != 3'h1});
      ext <= 8'hff;
      IRQ_MASK_I <= 1'b1;
      wt(8);
      chk({8'h0, EXT_IRQ_O}, 9'h0);
      IRQ_MASK_I <= 1'b0;
      if (i[0]) apb(1'b1, gpx_pkg::ADDR_SENS, 8'h06, 9'h0);
      else begin
        VECTOR_FETCH_I <= 1'b1;
        wt(1);
        VECTOR_FETCH_I <= 1'b0;
      end
      wt(4);
      chk({8'h0, EXT_IRQ_O}, 9'h0);
    end
    NRST_I <= 1'b0;
    wt(2);
    NRST_I <= 1'b1;
    wt(1);
    apb(1'b0, gpx_pkg::ADDR_OPT, 8'h0, 9'h0);
    apb(1'b0, gpx_pkg::ADDR_DIR, 8'h0, 9'h0);
    final_report;
  end
endmodule : gpx_port_tb
